// ---- logic/periph_irq_consts.vh ----
// Purpose: Constants for the peripheral interrupt flag, enable and priority bank.
// Assumes: Register indices are local choices; one register per address.
// Notes: Included by the bank module only.
`ifndef PERIPH_IRQ_CONSTS_VH
`define PERIPH_IRQ_CONSTS_VH

`define ADDR_W 3
`define A_FLAGS_1 3'h0
`define A_FLAGS_2 3'h1
`define A_ENABLE_1 3'h2
`define A_ENABLE_2 3'h3
`define A_PRIO_1 3'h4
`define A_PRIO_2 3'h5
`define A_CONTROL 3'h6

`define FLAGS_1_RST 8'h00
`define FLAGS_2_RST 8'h00
`define ENABLE_RST 8'h00
`define PRIO_RST 8'hFF
`define CONTROL_RST 8'h00

`define MASK_2 8'hDF
`define MASK_1_SMALL 8'h7F
`define MASK_1_FULL 8'hFF
`define MASK_CONTROL 8'h03

`define BIT_PRIO_ON 0
`define BIT_GROUP_EN 1

`define REG_W 8
`define FLAG_W 16
`define SET_NONE 8'h00
`define RDATA_IDLE 8'h00

`define POS_CAPCOMP_ONE 2
`define POS_TIMER_TWO 1
`define POS_TIMER_ONE 0
`define POS_OSC_FAIL 7
`define POS_COMPARATOR 6
`define POS_NV_WRITE 4
`define POS_BUS_COLL 3
`define POS_VOLTAGE 2
`define POS_TIMER_THREE 1
`define POS_CAPCOMP_TWO 0

`endif

// ---- logic/periph_irq_bank.v ----
// Purpose: Flag, enable and priority bank for peripheral interrupt sources.
// Assumes: Single clock, synchronous active-low reset, sources give one-cycle pulses.
// Notes: Flags 1 bits 7..3 are set by the flags_1_set input; bits 2..0 by named sources.
// Notes: Requests follow their flag by one edge and are registered levels.
// Notes: Global enable is a level from the core and is not stored here.
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "periph_irq_consts.vh"

module periph_irq_bank #(
    parameter SMALL_PACKAGE = 0
) (
    input wire core_clk,
    input wire rst_n,
    input wire [`ADDR_W-1:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [7:0] rdata,
    input wire [4:0] flags_1_set,
    input wire capcomp_one_compare_match,
    input wire capcomp_one_compare_mode,
    input wire timer_two_period_match,
    input wire timer_one_overflow,
    input wire osc_fail_switched,
    input wire comparator_change,
    input wire nv_write_done,
    input wire bus_collision,
    input wire voltage_detect_event,
    input wire timer_three_overflow,
    input wire capcomp_two_capture,
    input wire capcomp_two_capture_mode,
    input wire global_enable,
    output reg irq_high,
    output reg irq_low
);

    // The small package has no parallel port, so bit seven of every first
    // register is masked and can never be set, enabled or read back.
    localparam [7:0] MASK_1 = SMALL_PACKAGE ? `MASK_1_SMALL : `MASK_1_FULL;
    localparam [15:0] MASK_ALL = {`MASK_2, MASK_1};

    // Stored state: the two flag registers, two enable registers, two
    // priority registers and the two-bit control register.
    reg [7:0] flags_1_reg;
    reg [7:0] flags_2_reg;
    reg [7:0] periph_int_enable_1_reg;
    reg [7:0] periph_int_enable_2_reg;
    reg [7:0] periph_int_priority_1_reg;
    reg [7:0] periph_int_priority_2_reg;
    reg [7:0] control_reg;

    // Event and next-state vectors for the flag logic.
    reg [7:0] set_1;
    reg [7:0] set_2;
    wire [7:0] flags_1_next;
    wire [7:0] flags_2_next;
    wire [15:0] set_all;
    wire [15:0] flags_all;
    wire [15:0] flags_all_next;
    wire [15:0] wdata_all;

    // Sources qualified by their mode inputs.
    wire capcomp_one_event;
    wire capcomp_two_event;

    // Register port decode and read path.
    wire hit_flags_1;
    wire hit_flags_2;
    wire hit_enable_1;
    wire hit_enable_2;
    wire hit_prio_1;
    wire hit_prio_2;
    wire hit_control;
    wire sel_flags_1;
    wire sel_flags_2;
    wire sel_enable_1;
    wire sel_enable_2;
    wire sel_prio_1;
    wire sel_prio_2;
    wire sel_control;
    wire [7:0] rdata_next;

    // Request routing.
    wire [15:0] active;
    wire [15:0] prio;
    wire [15:0] prio_used;
    wire [15:0] route_high;
    wire [15:0] route_low;
    wire priority_levels_on;
    wire peripheral_group_enable;
    wire any_high;
    wire any_low;

    // Writes decode on the strobe; index 7 matches nothing, so a write
    // there is dropped without touching any register.
    assign hit_flags_1 = wr_stb && (addr == `A_FLAGS_1);
    assign hit_flags_2 = wr_stb && (addr == `A_FLAGS_2);
    assign hit_enable_1 = wr_stb && (addr == `A_ENABLE_1);
    assign hit_enable_2 = wr_stb && (addr == `A_ENABLE_2);
    assign hit_prio_1 = wr_stb && (addr == `A_PRIO_1);
    assign hit_prio_2 = wr_stb && (addr == `A_PRIO_2);
    assign hit_control = wr_stb && (addr == `A_CONTROL);

    // Reads decode without the strobe; the strobe only gates the capture
    // into the read data register.
    assign sel_flags_1 = (addr == `A_FLAGS_1);
    assign sel_flags_2 = (addr == `A_FLAGS_2);
    assign sel_enable_1 = (addr == `A_ENABLE_1);
    assign sel_enable_2 = (addr == `A_ENABLE_2);
    assign sel_prio_1 = (addr == `A_PRIO_1);
    assign sel_prio_2 = (addr == `A_PRIO_2);
    assign sel_control = (addr == `A_CONTROL);

    // A unit in the wrong mode produces no flag at all, so a stray strobe
    // from a unit in pulse-width mode cannot raise a request.
    // compare match only in compare mode.
    assign capcomp_one_event = capcomp_one_compare_match & capcomp_one_compare_mode;
    assign capcomp_two_event = capcomp_two_capture & capcomp_two_capture_mode;

    // Source map, flags_1: 7 parallel port, 6 converter, 5 serial receive,
    // 4 serial transmit, 3 sync serial, 2 capcomp one, 1 timer two, 0 timer one.
    // Source map, flags_2: 7 oscillator fail, 6 comparator, 5 unused,
    // 4 write done, 3 bus collision, 2 voltage detect, 1 timer three, 0 capcomp two.
    always @* begin
        set_1 = {flags_1_set, 3'h0};
        // compare match only in compare mode.
        set_1[`POS_CAPCOMP_ONE] = capcomp_one_event;
        set_1[`POS_TIMER_TWO] = timer_two_period_match;
        set_1[`POS_TIMER_ONE] = timer_one_overflow;
        set_2 = `SET_NONE;
        set_2[`POS_OSC_FAIL] = osc_fail_switched;
        set_2[`POS_COMPARATOR] = comparator_change;
        set_2[`POS_NV_WRITE] = nv_write_done;
        set_2[`POS_BUS_COLL] = bus_collision;
        // detector event, direction chosen by the detector.
        set_2[`POS_VOLTAGE] = voltage_detect_event;
        set_2[`POS_TIMER_THREE] = timer_three_overflow;
        set_2[`POS_CAPCOMP_TWO] = capcomp_two_event;
    end

    // Both flag registers are handled as one vector, first register low.
    assign set_all = {set_2, set_1};
    assign flags_all = {flags_2_reg, flags_1_reg};
    // The same write data serves both halves; the decode picks the half.
    assign wdata_all = {wdata, wdata};

    // A flag bit has no private state beyond its register bit, so one
    // generate loop covers all sixteen positions of both registers.
    genvar g;
    generate
        for (g = 0; g < `FLAG_W; g = g + 1) begin : g_flag
            wire write_hit;
            wire kept;
            if (g < `REG_W) begin : g_low
                assign write_hit = hit_flags_1;
            end else begin : g_high
                assign write_hit = hit_flags_2;
            end
            // An event in the same cycle as a clearing write wins, so no
            // event is ever lost; software that must be sure a flag is
            // clear reads it back after the write.
            // software write clears, set wins.
            assign kept = write_hit ? wdata_all[g] : flags_all[g];
            assign flags_all_next[g] = (kept | set_all[g]) & MASK_ALL[g];
        end
    endgenerate

    // Split back into the two registers.
    assign flags_1_next = flags_all_next[7:0];
    assign flags_2_next = flags_all_next[15:8];

    // Unmapped indices select nothing and so read as zero. Reading a flag
    // register has no side effect; only a write can clear it.
    assign rdata_next = ({`REG_W{sel_flags_1}} & flags_1_reg)
        | ({`REG_W{sel_flags_2}} & flags_2_reg)
        | ({`REG_W{sel_enable_1}} & periph_int_enable_1_reg)
        | ({`REG_W{sel_enable_2}} & periph_int_enable_2_reg)
        | ({`REG_W{sel_prio_1}} & periph_int_priority_1_reg)
        | ({`REG_W{sel_prio_2}} & periph_int_priority_2_reg)
        | ({`REG_W{sel_control}} & control_reg);

    // Flag registers take the merged next value on every edge; the
    // merge already holds the clear, the set and the bit masks.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            flags_1_reg <= `FLAGS_1_RST;
            flags_2_reg <= `FLAGS_2_RST;
        end else begin
            flags_1_reg <= flags_1_next;
            flags_2_reg <= flags_2_next;
        end
    end

    // enables reset to zero.
    // Bit seven is masked on the small package so it reads as zero.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            periph_int_enable_1_reg <= `ENABLE_RST;
        end else if (hit_enable_1) begin
            periph_int_enable_1_reg <= wdata & MASK_1;
        end
    end

    // enables reset to zero.
    // Bit five is masked and reads as zero.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            periph_int_enable_2_reg <= `ENABLE_RST;
        end else if (hit_enable_2) begin
            periph_int_enable_2_reg <= wdata & `MASK_2;
        end
    end

    // priorities reset high.
    // Every unmasked priority bit starts high; levels start off, so every source counts as low until control bit zero is set.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            periph_int_priority_1_reg <= `PRIO_RST & MASK_1;
        end else if (hit_prio_1) begin
            periph_int_priority_1_reg <= wdata & MASK_1;
        end
    end

    // masked positions stay zero.
    // Bit five reads as zero even straight out of reset.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            periph_int_priority_2_reg <= `PRIO_RST & `MASK_2;
        end else if (hit_prio_2) begin
            periph_int_priority_2_reg <= wdata & `MASK_2;
        end
    end

    // Only the two control bits are stored; the rest read as zero.
    // Bit zero turns on two levels, bit one is the group enable.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            control_reg <= `CONTROL_RST;
        end else if (hit_control) begin
            control_reg <= wdata & `MASK_CONTROL;
        end
    end

    // Read data is held only in the cycle after the strobe, so a missed
    // read cannot leave a stale value on the bus.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rdata <= `RDATA_IDLE;
        end else if (rd_stb) begin
            rdata <= rdata_next;
        end else begin
            rdata <= `RDATA_IDLE;
        end
    end

    assign priority_levels_on = control_reg[`BIT_PRIO_ON];
    assign peripheral_group_enable = control_reg[`BIT_GROUP_EN];

    assign active = {flags_2_reg & periph_int_enable_2_reg,
                     flags_1_reg & periph_int_enable_1_reg};
    assign prio = {periph_int_priority_2_reg, periph_int_priority_1_reg};

    // Each source is routed on its own, so a high source never hides a low
    // one that is pending at the same time.
    generate
        for (g = 0; g < `FLAG_W; g = g + 1) begin : g_route
            // With levels off every source counts as low priority.
            // priority bits only with levels on.
            assign prio_used[g] = priority_levels_on & prio[g];
            assign route_high[g] = active[g] & prio_used[g];
            assign route_low[g] = active[g] & ~prio_used[g];
        end
    endgenerate

    // Reduce to one request per level.
    assign any_high = |route_high;
    assign any_low = |route_low;

    // Requests register one cycle after flags so outputs come from flip-flops.
    // A request therefore follows its flag by one edge and falls one edge
    // after the flag is cleared.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            irq_high <= 1'b0;
            irq_low <= 1'b0;
        end else begin
            if (priority_levels_on) begin
                irq_high <= global_enable & any_high;
                irq_low <= global_enable & peripheral_group_enable & any_low;
            end else begin
                // Without levels no source can reach the high level.
                irq_high <= 1'b0;
                irq_low <= global_enable & peripheral_group_enable & any_low;
            end
        end
    end

endmodule // periph_irq_bank
`default_nettype wire

// ---- tb/periph_src_model.sv ----
// Purpose: Peripheral side of the bank, turning event requests into source pulses.
// Assumes: One request bit per flag position, flags_1 low byte first.
// Notes: A source line returns low once its one-cycle pulse is over.
`timescale 1ns/100ps
`default_nettype none
module periph_src_model (
    input wire logic core_clk,
    input wire logic [15:0] ev,
    output logic [15:0] pulse
);
    always_ff @(posedge core_clk) begin
        pulse <= ev;
    end
endmodule // periph_src_model
`default_nettype wire

// ---- tb/periph_irq_bank_monitor.sv ----
// Purpose: Assertions on the register port and request outputs.
// Assumes: A shadow mirrors the control register from bus writes.
// Notes: Flag contents are judged by the bench.
`timescale 1ns/100ps
`default_nettype none
module periph_irq_bank_monitor (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rdata,
    input wire logic global_enable,
    input wire logic irq_high,
    input wire logic irq_low
);
    logic [1:0] ctl;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge core_clk)
        ctl <= !rst_n ? 2'h0 : (wr_stb && addr == 3'h6) ? wdata[1:0] : ctl;
    chk_reset_quiet: assert property (!$past(rst_n) |-> !irq_high && !irq_low)
        else $error("request out of reset");
    chk_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00) else $error("stray data");
    chk_unmapped_read: assert property ($past(rd_stb && addr == 3'h7) |-> rdata == 8'h00)
        else $error("unmapped read");
    chk_bit5_zero: assert property ($past(rd_stb && addr[0] && addr < 3'h6) |-> !rdata[5])
        else $error("bit five set");
    chk_ctl_read: assert property ($past(rd_stb && addr == 3'h6) |-> rdata == {6'h00, $past(ctl)})
        else $error("control read");
    chk_no_global: assert property (!$past(global_enable) |-> !(irq_high || irq_low))
        else $error("request without global");
    chk_group_gate: assert property (!$past(ctl[1]) |-> !irq_low) else $error("low gate");
    chk_levels_off: assert property (!$past(ctl[0]) |-> !irq_high) else $error("high gate");
    cover property (irq_high);
    cover property (irq_low);
    cover property ($past(rd_stb && addr == 3'h6));
endmodule // periph_irq_bank_monitor
bind periph_irq_bank periph_irq_bank_monitor i_mon (.core_clk, .rst_n, .addr, .wdata, .wr_stb,
    .rd_stb, .rdata, .global_enable, .irq_high, .irq_low);
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: Random and corner checks of the interrupt flag bank.
// Assumes: Event pulses come from the peripheral model.
// Notes: Expected values come from local tables and functions.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [7:0] MSK [8] = '{8'h00, 8'h00, 8'hFF, 8'hDF, 8'hFF, 8'hDF, 8'h03, 8'h00};
    logic core_clk = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, global_enable = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [15:0] ev = 16'h0000, pulse, v;
    logic [1:0] md = 2'h0, irq;
    int err_total = 0, n_checks = 0, seed = 32'h32F5;
    periph_src_model i_periph_src_model (.core_clk, .ev, .pulse);
    periph_irq_bank i_periph_irq_bank (.core_clk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
        .flags_1_set(pulse[7:3]), .capcomp_one_compare_match(pulse[2]),
        .capcomp_one_compare_mode(md[0]), .timer_two_period_match(pulse[1]),
        .timer_one_overflow(pulse[0]), .osc_fail_switched(pulse[15]), .comparator_change(pulse[14]),
        .nv_write_done(pulse[12]), .bus_collision(pulse[11]), .voltage_detect_event(pulse[10]),
        .timer_three_overflow(pulse[9]), .capcomp_two_capture(pulse[8]),
        .capcomp_two_capture_mode(md[1]), .global_enable, .irq_high(irq[1]), .irq_low(irq[0]));
    initial forever #50 core_clk = ~core_clk;
    function automatic logic [7:0] flags(input logic [15:0] e, input int a);
        logic [15:0] f;
        f = e & 16'hDFFF & ~{7'h00, ~e[13], 5'h00, ~e[5], 2'h0};
        return a ? f[15:8] : f[7:0];
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // A read passes its expected value in d and is judged in the answer cycle.
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= w;
        rd_stb <= !w;
        @(posedge core_clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        @(negedge core_clk);
        if (!w) cmp(rdata, d);
    endtask
    task automatic fire(input logic [15:0] e, input logic [1:0] m);
        @(posedge core_clk);
        ev <= e;
        md <= m;
        @(posedge core_clk);
        ev <= 16'h0000;
    endtask
    task automatic conclude();
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #1_000_000;
        err_total++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 8; a++) acc(1'b0, a[2:0], a[2:1] == 2'h2 ? MSK[a] : 8'h00);
        repeat (40) begin
            v = $random(seed);
            fire(v, {v[13], v[5]});
            for (int a = 0; a < 2; a++) begin
                acc(1'b0, a[2:0], flags(v, a));
                acc(1'b1, a[2:0], 8'h00);
                acc(1'b0, a[2:0], 8'h00);
            end
        end
        for (int a = 2; a < 8; a++) begin
            v = $random(seed);
            acc(1'b1, a[2:0], v[7:0]);
            acc(1'b0, a[2:0], v[7:0] & MSK[a]);
        end
        acc(1'b1, 3'h2, 8'hFF);
        acc(1'b1, 3'h3, 8'hFF);
        repeat (32) begin
            v = $random(seed);
            acc(1'b1, 3'h4, {8{v[4]}});
            acc(1'b1, 3'h5, {8{v[4]}});
            acc(1'b1, 3'h6, {6'h00, v[6:5]});
            @(posedge core_clk);
            global_enable <= v[7];
            fire(16'h0001 << v[3:0], 2'h3);
            repeat (2) @(posedge core_clk);
            #1 cmp({6'h00, irq}, v[3:0] == 4'hD || !v[7] ? 8'h00 :
                v[5] && v[4] ? 8'h02 : {7'h00, v[6]});
            acc(1'b1, 3'h0, 8'h00);
            acc(1'b1, 3'h1, 8'h00);
        end
        conclude();
    end
endmodule // tb_top
`default_nettype wire
